// [gti_top.sv]
// device-side talker/listener interface for the instrument bus
`timescale 1ns/10ps
module gti_top
	import gti_pkg::*;
(
	// clock, reset, clock enable
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	// bus data lines, active low
	input wire logic [7:0] DIO_N_IN,
	output logic [7:0] DIO_N_OUT,
	output logic [7:0] DIO_N_OE,
	// bus management lines, active low
	input wire logic ATN_N_IN,
	input wire logic IFC_N_IN,
	input wire logic REN_N_IN,
	input wire logic EOI_N_IN,
	output logic EOI_N_OUT,
	output logic EOI_N_OE,
	output logic SRQ_N_OUT,
	output logic SRQ_N_OE,
	// handshake lines, active low
	input wire logic DAV_N_IN,
	output logic DAV_N_OUT,
	output logic DAV_N_OE,
	input wire logic NRFD_N_IN,
	output logic NRFD_N_OUT,
	output logic NRFD_N_OE,
	input wire logic NDAC_N_IN,
	output logic NDAC_N_OUT,
	output logic NDAC_N_OE,
	// address setting
	input wire logic [4:0] ADDR_VALUE,
	input wire logic ADDR_WRITE,
	output logic [4:0] ADDR,
	// received data stream
	output logic [7:0] RX_DATA,
	output logic RX_VALID,
	output logic RX_END,
	input wire logic RX_READY,
	// transmit data stream
	input wire logic [7:0] TX_DATA,
	input wire logic TX_END,
	input wire logic TX_VALID,
	output logic TX_READY,
	// service request
	input wire logic SRQ_SET,
	input wire logic SRQ_CLEAR,
	// status and events
	output logic LISTENING,
	output logic TALKING,
	output logic REMOTE,
	output logic LOCKOUT,
	output logic CLEAR_PULSE,
	output logic TRIGGER_PULSE
);
	logic [11:0] raw_lines;
	logic [11:0] sync_lines;
	logic [7:0] bus_data;
	logic atn, ifc, ren, eoi, dav, nrfd, ndac;
	logic byte_taken;
	logic [7:0] taken_byte;
	logic taken_eoi;
	logic cmd_taken;
	logic acc_active;
	logic srq_flag;
	logic ren_seen;
	logic [7:0] tx_byte;
	logic tx_last;
	logic tx_full;
	gti_src_e src_state;
	gti_acc_e acc_state;

	// ****************************************************************
	// input synchronisation and polarity
	// ****************************************************************
	assign raw_lines = {DIO_N_IN, ATN_N_IN, IFC_N_IN, REN_N_IN, EOI_N_IN};

	gti_sync #(.WIDTH(12)) u_sync_a
	(
		.clk(CLK_SYS),
		.reset(RESET),
		.ce(CE),
		.async_in(raw_lines),
		.sync_out(sync_lines)
	);

	logic [2:0] hs_sync;
	gti_sync #(.WIDTH(3)) u_sync_b
	(
		.clk(CLK_SYS),
		.reset(RESET),
		.ce(CE),
		.async_in({DAV_N_IN, NRFD_N_IN, NDAC_N_IN}),
		.sync_out(hs_sync)
	);

	// low level is true on every line
	assign bus_data = ~sync_lines[11:4];
	assign atn = ~sync_lines[3];
	assign ifc = ~sync_lines[2];
	assign ren = ~sync_lines[1];
	assign eoi = ~sync_lines[0];
	assign dav = ~hs_sync[2];
	assign nrfd = ~hs_sync[1];
	assign ndac = ~hs_sync[0];

	function automatic logic is_own(input logic [7:0] b, input logic [7:0] base, input logic [4:0] a);
		is_own = (b[6:0] == (base[6:0] | {2'b00, a}));
	endfunction

	// ****************************************************************
	// primary address
	// ****************************************************************
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			ADDR <= PRI_ADDR_RESET;
		else if (CE && ADDR_WRITE && ADDR_VALUE <= PRI_ADDR_MAX)
			ADDR <= ADDR_VALUE;
	end

	// ****************************************************************
	// acceptor handshake
	// ****************************************************************
	// accept while attention is true (every device must take commands) or when listening
	assign acc_active = atn || LISTENING;

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			acc_state <= ACC_READY;
			taken_byte <= 8'h00;
			taken_eoi <= 1'b0;
		end
		else if (CE)
		begin
			case (acc_state)
				ACC_READY:
					if (acc_active && dav)
					begin
						taken_byte <= bus_data;
						taken_eoi <= eoi;
						acc_state <= ACC_HOLD;
					end
				ACC_HOLD:
					// data bytes wait for the user stream to have room
					if (atn || !RX_VALID || RX_READY)
						acc_state <= ACC_WAIT_DROP;
				ACC_WAIT_DROP:
					if (!dav)
						acc_state <= ACC_READY;
				default:
					acc_state <= ACC_READY;
			endcase
		end
	end

	assign byte_taken = CE && acc_state == ACC_HOLD && (atn || !RX_VALID || RX_READY);
	assign cmd_taken = byte_taken && atn;

	// not-ready held except while waiting idle; not-accepted released once taken
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			NRFD_N_OE <= 1'b0;
			NDAC_N_OE <= 1'b0;
		end
		else if (CE)
		begin
			NRFD_N_OE <= acc_active && !(acc_state == ACC_READY && !dav);
			NDAC_N_OE <= acc_active && !(acc_state == ACC_WAIT_DROP);
		end
	end
	assign NRFD_N_OUT = 1'b0;
	assign NDAC_N_OUT = 1'b0;

	// ****************************************************************
	// received data stream
	// ****************************************************************
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			RX_VALID <= 1'b0;
			RX_DATA <= 8'h00;
			RX_END <= 1'b0;
		end
		else if (CE)
		begin
			if (byte_taken && !atn && LISTENING)
			begin
				RX_VALID <= 1'b1;
				RX_DATA <= taken_byte;
				RX_END <= taken_eoi;
			end
			else if (RX_READY)
				RX_VALID <= 1'b0;
		end
	end

	// ****************************************************************
	// addressing and bus commands
	// ****************************************************************
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			LISTENING <= 1'b0;
			TALKING <= 1'b0;
		end
		else if (CE)
		begin
			if (ifc)
			begin
				LISTENING <= 1'b0;
				TALKING <= 1'b0;
			end
			else if (cmd_taken)
			begin
				// secondary range 0x60-0x7f matches nothing here
				if (is_own(taken_byte, LISTEN_BASE, ADDR))
					LISTENING <= 1'b1;
				else if (taken_byte[6:0] == CMD_UNL[6:0])
					LISTENING <= 1'b0;
				if (is_own(taken_byte, TALK_BASE, ADDR))
					TALKING <= 1'b1;
				else if (taken_byte[6:0] == CMD_UNT[6:0])
					TALKING <= 1'b0;
				else if (taken_byte[6:5] == 2'b10)
					TALKING <= 1'b0; // only one talker: another talk address idles us
			end
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			REMOTE <= 1'b0;
			LOCKOUT <= 1'b0;
			CLEAR_PULSE <= 1'b0;
			TRIGGER_PULSE <= 1'b0;
			ren_seen <= 1'b0;
		end
		else if (CE)
		begin
			CLEAR_PULSE <= cmd_taken && (taken_byte[6:0] == CMD_DCL[6:0]
				|| (LISTENING && taken_byte[6:0] == CMD_SDC[6:0]));
			TRIGGER_PULSE <= cmd_taken && LISTENING && taken_byte[6:0] == CMD_GET[6:0];
			ren_seen <= ren;
			if (!ren)
			begin
				REMOTE <= 1'b0;
				LOCKOUT <= 1'b0;
			end
			else if (cmd_taken && LISTENING && taken_byte[6:0] == CMD_GTL[6:0])
				REMOTE <= 1'b0;
			// remote entered as enable rises or on our listen address, so that
			// a go-to-local holds while enable stays true
			else if (!ren_seen || (cmd_taken && is_own(taken_byte, LISTEN_BASE, ADDR)))
				REMOTE <= 1'b1;
			if (ren && cmd_taken && taken_byte[6:0] == CMD_LLO[6:0])
				LOCKOUT <= 1'b1;
		end
	end

	// ****************************************************************
	// source handshake
	// ****************************************************************
	// one byte holding stage, the user stream stalls on TX_READY
	// TX_READY is kept registered as the inverse of tx_full, low in reset

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			src_state <= SRC_IDLE;
			TX_READY <= 1'b0;
			tx_full <= 1'b0;
			tx_byte <= 8'h00;
			tx_last <= 1'b0;
		end
		else if (CE)
		begin
			TX_READY <= !tx_full;
			if (TX_VALID && TX_READY)
			begin
				tx_full <= 1'b1;
				TX_READY <= 1'b0;
				tx_byte <= TX_DATA;
				tx_last <= TX_END;
			end
			case (src_state)
				SRC_IDLE:
					if (tx_full && TALKING && !atn)
						src_state <= SRC_WAIT_READY;
				SRC_WAIT_READY:
					if (!TALKING || atn)
						src_state <= SRC_IDLE;
					else if (!nrfd)
						src_state <= SRC_VALID;
				SRC_VALID:
					if (!ndac)
						src_state <= SRC_WAIT_TAKEN;
				SRC_WAIT_TAKEN:
				begin
					tx_full <= 1'b0;
					TX_READY <= 1'b1;
					src_state <= SRC_IDLE;
				end
				default:
					src_state <= SRC_IDLE;
			endcase
			if (ifc || (atn && src_state == SRC_VALID))
				src_state <= SRC_IDLE;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			DIO_N_OE <= 8'h00;
			DIO_N_OUT <= 8'hff;
			DAV_N_OE <= 1'b0;
			EOI_N_OE <= 1'b0;
		end
		else if (CE)
		begin
			// data lines released whenever we are not sourcing
			// pull low only the lines whose bit is a one; zero bits stay released
			DIO_N_OE <= (TALKING && !atn && src_state != SRC_IDLE) ? tx_byte : 8'h00;
			DIO_N_OUT <= ~tx_byte;
			DAV_N_OE <= src_state == SRC_VALID && TALKING && !atn && !ifc;
			EOI_N_OE <= TALKING && !atn && src_state != SRC_IDLE && tx_last;
		end
	end
	assign DAV_N_OUT = 1'b0;
	assign EOI_N_OUT = 1'b0;

	// ****************************************************************
	// service request
	// ****************************************************************
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
			srq_flag <= 1'b0;
		else if (CE)
		begin
			if (SRQ_SET)
				srq_flag <= 1'b1;
			else if (SRQ_CLEAR)
				srq_flag <= 1'b0;
		end
	end
	assign SRQ_N_OE = srq_flag;
	assign SRQ_N_OUT = 1'b0;
endmodule

// [gti_pkg.sv]
// constants shared by the instrument bus talker/listener interface
// ****************************************************************
// Summary of operation
// ****************************************************************
package gti_pkg;
	localparam logic [4:0] PRI_ADDR_RESET = 5'h0f;
	localparam logic [4:0] PRI_ADDR_MAX = 5'h1e;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam logic [7:0] CMD_GTL = 8'h01;
	localparam logic [7:0] CMD_SDC = 8'h04;
	localparam logic [7:0] CMD_GET = 8'h08;
	localparam logic [7:0] CMD_LLO = 8'h11;
	localparam logic [7:0] CMD_DCL = 8'h14;
	localparam logic [7:0] CMD_UNL = 8'h3f;
	localparam logic [7:0] CMD_UNT = 8'h5f;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0]
	{
		SRC_IDLE = 2'b00,
		SRC_WAIT_READY = 2'b01,
		SRC_VALID = 2'b10,
		SRC_WAIT_TAKEN = 2'b11
	} gti_src_e;
	typedef enum logic [1:0]
	{
		ACC_READY = 2'b00,
		ACC_HOLD = 2'b01,
		ACC_WAIT_DROP = 2'b10
	} gti_acc_e;
endpackage

// [gti_sync.sv]
// two-stage synchroniser for bus lines arriving without a clock
`timescale 1ns/10ps
module gti_sync
#(
	parameter int WIDTH = 8
)
(
	// clocking
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// lines
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// resets to all ones: a released (false) active-low line
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			stage1 <= '1;
			sync_out <= '1;
		end
		else if (ce)
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// [gti_monitor.sv]
// assertion checker for the bus interface ports
`timescale 1ns/10ps
module gti_monitor
(
	// clock and reset
	input logic CLK_SYS,
	input logic RESET,
	input logic CE,
	// address setting
	input logic [4:0] ADDR_VALUE,
	input logic ADDR_WRITE,
	input logic [4:0] ADDR,
	// bus lines
	input logic [7:0] DIO_N_OE,
	input logic IFC_N_IN,
	input logic REN_N_IN,
	input logic DAV_N_IN,
	input logic NRFD_N_IN,
	input logic NDAC_N_IN,
	input logic DAV_N_OE,
	input logic NRFD_N_OE,
	input logic NDAC_N_OE,
	// status
	input logic LISTENING,
	input logic TALKING,
	input logic REMOTE,
	input logic LOCKOUT
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	// ****
	// handshake steps
	// ****
	sequence taken_s;
		$fell(NDAC_N_OE) && $past(NRFD_N_OE);
	endsequence
	sequence src_on_s;
		$rose(DAV_N_OE);
	endsequence
	sequence src_off_s;
		$fell(DAV_N_OE);
	endsequence
	accept_order_a:
		assert property (taken_s |-> NRFD_N_OE) else $error("ready during take");
	src_ready_a:
		assert property (src_on_s |-> $past(NRFD_N_IN, 2)) else $error("valid before ready");
	src_done_a:
		assert property (src_off_s |-> $past(NDAC_N_IN, 2)) else $error("valid dropped early");
	dio_idle_a:
		assert property (!TALKING [*2] |-> DIO_N_OE == 8'h00) else $error("data driven idle");
	addr_range_a:
		assert property (ADDR <= 5'h1e) else $error("address above 30");
	addr_load_a:
		assert property (ADDR_WRITE && CE && ADDR_VALUE <= 5'h1e |=> ADDR == $past(ADDR_VALUE))
		else $error("address not loaded");
	ifc_idle_a:
		assert property ((!IFC_N_IN && CE) [*4] |=> !LISTENING && !TALKING) else $error("clear");
	ren_local_a:
		assert property ((REN_N_IN && CE) [*4] |=> !REMOTE && !LOCKOUT) else $error("remote");
endmodule
bind gti_top gti_monitor u_mon (.*);

// [gti_ctl_model.sv]
// far-side model: bus controller that also listens to the device
`timescale 1ns/10ps
module gti_ctl_model
(
	// clock and wired bus levels
	input logic clk,
	input logic [7:0] dio_w,
	input logic dav_w,
	input logic nrfd_w,
	input logic ndac_w,
	input logic eoi_w,
	// own drive, high means released
	output logic [7:0] dio_n,
	output logic atn_n,
	output logic eoi_n,
	output logic dav_n,
	output logic nrfd_n,
	output logic ndac_n
);
	// idles as a stalled acceptor so a talker never sends into an empty bus
	initial
	begin
		{dio_n, atn_n, eoi_n, dav_n} = 11'h7ff;
		{nrfd_n, ndac_n} = 2'b00;
	end
	task set_atn(input logic a);
		@(negedge clk);
		atn_n = !a;
	endtask
	task put(input logic a, input logic [7:0] d, input logic e);
		@(negedge clk);
		{nrfd_n, ndac_n} = 2'b11;
		{atn_n, dio_n, eoi_n} = {!a, ~d, !e};
		@(negedge clk);
		// an acceptor must hold not-accepted and be ready before data valid
		while (!nrfd_w || ndac_w) @(negedge clk);
		dav_n = 1'b0;
		@(negedge clk);
		while (!ndac_w) @(negedge clk);
		dav_n = 1'b1;
		// released lines float back to the termination level
		{dio_n, eoi_n} = 9'h1ff;
		{nrfd_n, ndac_n} = 2'b00;
	endtask
	task get(input int s, output logic [7:0] d, output logic e);
		repeat (s) @(negedge clk);
		nrfd_n = 1'b1;
		while (dav_w) @(negedge clk);
		{d, e} = {~dio_w, !eoi_w};
		nrfd_n = 1'b0;
		repeat (s) @(negedge clk);
		ndac_n = 1'b1;
		while (!dav_w) @(negedge clk);
		ndac_n = 1'b0;
	endtask
endmodule

// [gti_tb_top.sv]
// self-checking testbench for the bus interface
`timescale 1ns/10ps
module gti_tb_top;
	import gti_pkg::*;
	logic CLK_SYS, RESET, CE, ADDR_WRITE, RX_READY, TX_END, TX_VALID, SRQ_SET, SRQ_CLEAR;
	logic IFC_N_IN, REN_N_IN, ATN_N_IN, EOI_N_IN, DAV_N_IN, NRFD_N_IN, NDAC_N_IN, e;
	logic EOI_N_OUT, EOI_N_OE, SRQ_N_OUT, SRQ_N_OE, DAV_N_OUT, DAV_N_OE, NRFD_N_OUT;
	logic NRFD_N_OE, NDAC_N_OUT, NDAC_N_OE, TX_READY, RX_VALID, RX_END, LISTENING;
	logic TALKING, REMOTE, LOCKOUT, CLEAR_PULSE, TRIGGER_PULSE, m_eoi, m_dav, m_nrfd, m_ndac;
	logic [4:0] ADDR_VALUE, ADDR;
	logic [7:0] DIO_N_IN, DIO_N_OUT, DIO_N_OE, TX_DATA, RX_DATA, m_dio, b;
	int err_total = 0;
	int check_count = 0;
	int clr_n = 0;
	int trg_n = 0;
	// every input sees the wired level of all drivers
	assign DIO_N_IN = m_dio & ~(DIO_N_OE & ~DIO_N_OUT);
	assign EOI_N_IN = m_eoi & ~(EOI_N_OE & ~EOI_N_OUT);
	assign DAV_N_IN = m_dav & ~(DAV_N_OE & ~DAV_N_OUT);
	assign NRFD_N_IN = m_nrfd & ~(NRFD_N_OE & ~NRFD_N_OUT);
	assign NDAC_N_IN = m_ndac & ~(NDAC_N_OE & ~NDAC_N_OUT);
	gti_top u_dut (.*);
	gti_ctl_model u_ctl (.clk(CLK_SYS), .dio_w(DIO_N_IN), .dav_w(DAV_N_IN), .nrfd_w(NRFD_N_IN),
		.ndac_w(NDAC_N_IN), .eoi_w(EOI_N_IN), .dio_n(m_dio), .atn_n(ATN_N_IN), .eoi_n(m_eoi),
		.dav_n(m_dav), .nrfd_n(m_nrfd), .ndac_n(m_ndac));
	// ****
	// clock, pulse counters, tasks
	// ****
	initial
	begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS)
	begin
		if (CLEAR_PULSE === 1'b1)
			clr_n++;
		if (TRIGGER_PULSE === 1'b1)
			trg_n++;
	end
	task chk(input logic [7:0] g, input logic [7:0] x);
		check_count++;
		if (g !== x)
		begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task set_addr(input logic [4:0] v);
		@(negedge CLK_SYS);
		{ADDR_VALUE, ADDR_WRITE} = {v, 1'b1};
		@(negedge CLK_SYS);
		ADDR_WRITE = 1'b0;
	endtask
	task send(input logic [7:0] d, input logic t);
		@(negedge CLK_SYS);
		while (TX_READY !== 1'b1) @(negedge CLK_SYS);
		{TX_DATA, TX_END, TX_VALID} = {d, t, 1'b1};
		@(negedge CLK_SYS);
		TX_VALID = 1'b0;
	endtask
	task results();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// the tests need a few hundred cycles; ten thousand means a hang
	initial
	begin
		#50000;
		err_total++;
		results();
	end
	initial
	begin
		{RESET, CE, IFC_N_IN, REN_N_IN, RX_READY, ADDR_WRITE, TX_END, TX_VALID} = 8'hf8;
		{SRQ_SET, SRQ_CLEAR, ADDR_VALUE, TX_DATA} = 15'h0000;
		repeat (2) @(negedge CLK_SYS);
		RESET = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		chk({3'h0, ADDR}, 8'h0f);
		chk({DIO_N_OE[0], DAV_N_OE, SRQ_N_OE, LISTENING, TALKING, 3'h0}, 8'h00);
		set_addr(5'h1f);
		chk({3'h0, ADDR}, 8'h0f);
		set_addr(5'h1e);
		chk({3'h0, ADDR}, 8'h1e);
		set_addr(5'h0f);
		$display("address test done");
		u_ctl.put(1'b1, 8'h2f, 1'b0);
		u_ctl.put(1'b1, 8'h6f, 1'b0);
		chk({7'h0, LISTENING}, 8'h01);
		REN_N_IN = 1'b0;
		u_ctl.put(1'b1, CMD_LLO, 1'b0);
		chk({6'h0, REMOTE, LOCKOUT}, 8'h03);
		u_ctl.put(1'b1, CMD_SDC, 1'b0);
		u_ctl.put(1'b1, CMD_GET, 1'b0);
		u_ctl.put(1'b1, CMD_DCL, 1'b0);
		u_ctl.put(1'b1, CMD_GTL, 1'b0);
		chk({clr_n[3:0], trg_n[3:0]}, 8'h21);
		chk({7'h0, REMOTE}, 8'h00);
		RX_READY = 1'b0;
		u_ctl.put(1'b0, 8'ha5, 1'b1);
		chk({RX_VALID, RX_END, 6'h0}, 8'hc0);
		chk(RX_DATA, 8'ha5);
		RX_READY = 1'b1;
		u_ctl.put(1'b1, CMD_UNL, 1'b0);
		u_ctl.put(1'b1, CMD_SDC, 1'b0);
		chk({LISTENING, 3'h0, clr_n[3:0]}, 8'h02);
		$display("listener test done");
		u_ctl.put(1'b1, 8'h4f, 1'b0);
		chk({7'h0, TALKING}, 8'h01);
		u_ctl.set_atn(1'b0);
		fork
			begin
				send(8'ha5, 1'b0);
				send(8'hc3, 1'b1);
			end
			begin
				u_ctl.get(0, b, e);
				chk(b, 8'ha5);
				chk({7'h0, e}, 8'h00);
				u_ctl.get(3, b, e);
				chk(b, 8'hc3);
				chk({7'h0, e}, 8'h01);
			end
		join
		u_ctl.put(1'b1, CMD_UNT, 1'b0);
		chk({7'h0, TALKING}, 8'h00);
		$display("talker test done");
		u_ctl.put(1'b1, 8'h2f, 1'b0);
		u_ctl.put(1'b1, 8'h4f, 1'b0);
		IFC_N_IN = 1'b0;
		repeat (5) @(negedge CLK_SYS);
		chk({6'h0, LISTENING, TALKING}, 8'h00);
		{IFC_N_IN, REN_N_IN} = 2'b11;
		repeat (5) @(negedge CLK_SYS);
		chk({6'h0, REMOTE, LOCKOUT}, 8'h00);
		$display("clear test done");
		SRQ_SET = 1'b1;
		@(negedge CLK_SYS);
		{SRQ_SET, SRQ_CLEAR} = 2'b00;
		repeat (3) @(negedge CLK_SYS);
		chk({7'h0, SRQ_N_OE}, 8'h01);
		SRQ_CLEAR = 1'b1;
		@(negedge CLK_SYS);
		SRQ_CLEAR = 1'b0;
		@(negedge CLK_SYS);
		chk({7'h0, SRQ_N_OE}, 8'h00);
		$display("service test done");
		results();
	end
endmodule
